// ==== shared/io_port_pkg.sv ====
// package: register map, field layouts, reset values and timing counts for the i/o port block
package io_port_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PORT3_EVENT_MASK = 8'hC7;
    localparam logic [7:0] IDX_PORT4_EVENT_MASK = 8'hC8;
    localparam logic [7:0] IDX_PORT3_EVENT_STATUS = 8'hE7;
    localparam logic [7:0] IDX_PORT4_EVENT_STATUS = 8'hE8;
    localparam logic [7:0] IDX_SUSPEND_LED_MODE = 8'hF3;
    localparam logic [7:0] IDX_PORT4_DIRECTION = 8'hF4;
    localparam logic [7:0] IDX_PORT4_PIN_DATA = 8'hF5;
    localparam logic [7:0] IDX_PORT4_POLARITY_INVERT = 8'hF6;
    localparam logic [7:0] IDX_PORT4_FUNCTION_SELECT = 8'hF7;
    localparam logic [7:0] IDX_PORT3_DETECT_TYPE = 8'hFE;

    localparam int APB_ADDR_W = 12;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_PIN_DATA = 8'h00;
    localparam logic [7:0] RST_INVERT = 8'h00;
    localparam logic [7:0] RST_FUNCTION = 8'h00;
    localparam logic [7:0] RST_DETECT_TYPE = 8'h00;
    localparam logic [1:0] RST_LED_MODE = 2'h0;
    localparam logic [7:0] RST_MASK = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int LED_MODE_LSB = 6;
    localparam int DEBOUNCE_EN_LSB = 4;
    localparam int TRIGGER_LEVEL_LSB = 0;
    // port3 detect pins in order: pin0, pin1, pin5
    localparam int DETECT_PIN_POS [3] = '{0, 1, 5};

    // ------------------------------------------------------------
    // suspend led modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LED_TRISTATE = 2'b00,
        LED_DRIVE_LOW = 2'b01,
        LED_BLINK_FAST = 2'b10,
        LED_BLINK_SLOW = 2'b11
    } led_mode_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint LED_FAST_PERIOD_MS = 1000;
    localparam longint LED_SLOW_PERIOD_MS = 4000;
    localparam logic [27:0] LED_FAST_HALF_CYCLES =
        28'(LED_FAST_PERIOD_MS * 64'd1000000 / CLK_PERIOD_NS / 2);
    localparam logic [27:0] LED_SLOW_HALF_CYCLES =
        28'(LED_SLOW_PERIOD_MS * 64'd1000000 / CLK_PERIOD_NS / 2);
    localparam logic [4:0] DEBOUNCE_CYCLES = 5'h10;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] direction;
        logic [7:0] pin_data;
        logic [7:0] invert;
        logic [7:0] function_sel;
    } port4_cfg_t;

    typedef struct packed {
        logic [7:0] port3;
        logic [7:0] port4;
    } event_bits_t;

endpackage

// ==== rtl/pin_sync.sv ====
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // ------------------------------------------------------------
    // per-bit stages
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_reg, s2_reg, s3_reg, out_reg;
            logic out_next;
            // accept the level only when stage two and three match
            always_comb begin
                out_next = (s2_reg == s3_reg) ? s3_reg : out_reg;
            end
            // stage one feeds stage two only
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    out_reg <= 1'b0;
                end else begin
                    s1_reg <= async_in[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    out_reg <= out_next;
                end
            end
            assign sync_out[i] = out_reg;
        end
    endgenerate
endmodule

// ==== rtl/led_blinker.sv ====
// suspend led pattern generator: tri-state, low, or two blink rates at half duty
`timescale 1ns/10ps
module led_blinker
    import io_port_pkg::*;
#(
    parameter logic [27:0] FAST_HALF = LED_FAST_HALF_CYCLES,
    parameter logic [27:0] SLOW_HALF = LED_SLOW_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire led_mode_t mode,
    output logic led_level,
    output logic led_drive
);
    logic [27:0] count_reg, count_next;
    logic phase_reg, phase_next;
    logic [27:0] half;

    // ------------------------------------------------------------
    // half period counter and phase
    // ------------------------------------------------------------
    always_comb begin
        half = (mode == LED_BLINK_SLOW) ? SLOW_HALF : FAST_HALF;
        count_next = count_reg + 28'h1;
        phase_next = phase_reg;
        if (mode == LED_TRISTATE || mode == LED_DRIVE_LOW) begin
            count_next = 28'h0;
            phase_next = 1'b0;
        end else if (count_reg >= half - 28'h1) begin
            count_next = 28'h0;
            phase_next = ~phase_reg; // 50% duty
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count_reg <= 28'h0;
            phase_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            phase_reg <= phase_next;
        end
    end

    assign led_level = phase_reg;
    assign led_drive = (mode != LED_TRISTATE);
endmodule

// ==== rtl/io_port_four_with_pin_mux.sv ====
// eight-pin i/o port with function mux, port3 detect pins, event status and apb registers
//
// Operation
// - direction bit 0 output, 1 input; reset all ones
// - output pins: data readable, writable, drives pin
// - input pins: read pin value, ignore writes
// - inversion bit inverts pin both directions
// - odd select bits suspend led, even watchdog
// - port3 bits 6..4 enable input debouncer
// - port3 bits 2..0: 0 edge, 1 level
// - edge sets event status; read clears bits
// - suspend led: tristate, low, 1Hz, 0.25Hz
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
module io_port_four_with_pin_mux
    import io_port_pkg::*;
#(
    parameter logic [27:0] LED_FAST_HALF = LED_FAST_HALF_CYCLES,
    parameter logic [27:0] LED_SLOW_HALF = LED_SLOW_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] io_port_four_in,
    output logic [7:0] io_port_four_out,
    output logic [7:0] io_port_four_oe,
    input wire logic [2:0] io_port_three_detect_in,
    input wire logic watchdog_timeout_out_n,
    output logic irq
);
    // --------------------
    // declarations
    // --------------------
    port4_cfg_t cfg_reg, cfg_next;
    logic [7:0] detect_type_reg, detect_type_next;
    led_mode_t led_mode_reg, led_mode_next;
    event_bits_t status_reg, status_next;
    event_bits_t mask_reg, mask_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [7:0] pin_out_reg, pin_out_next;
    logic [7:0] pin_oe_reg, pin_oe_next;
    logic irq_reg, irq_next;

    logic [7:0] p4_sync;
    logic [7:0] p4_prev_reg;
    logic [2:0] p3_sync;
    logic [2:0] p3_clean;
    logic [2:0] p3_prev_reg;
    logic led_level, led_drive;

    logic [7:0] reg_index;
    logic addr_ok;
    logic setup_phase;
    logic access_done;
    logic [7:0] data_view;
    logic [7:0] read_byte;
    logic read_hit;
    event_bits_t event_set;
    event_bits_t read_clear;

    // --------------------
    // pin input synchronisers
    // --------------------
    pin_sync #(.WIDTH(8)) u_sync_p4 (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(io_port_four_in),
        .sync_out(p4_sync)
    );

    pin_sync #(.WIDTH(3)) u_sync_p3 (
        .clk(clk),
        .sys_rst(sys_rst),
        .async_in(io_port_three_detect_in),
        .sync_out(p3_sync)
    );

    // --------------------
    // suspend led pattern
    // --------------------
    led_blinker #(
        .FAST_HALF(LED_FAST_HALF),
        .SLOW_HALF(LED_SLOW_HALF)
    ) u_led (
        .clk(clk),
        .sys_rst(sys_rst),
        .mode(led_mode_reg),
        .led_level(led_level),
        .led_drive(led_drive)
    );

    // --------------------
    // port3 debouncers, one per detect pin
    // --------------------
    genvar d;
    generate
        for (d = 0; d < 3; d++) begin : g_deb
            logic [4:0] cnt_reg, cnt_next;
            logic stable_reg, stable_next;
            logic enable;
            // restart the count on every change of the raw level
            always_comb begin
                enable = detect_type_reg[DEBOUNCE_EN_LSB + d];
                cnt_next = cnt_reg;
                stable_next = stable_reg;
                if (!enable) begin
                    cnt_next = 5'h0;
                    stable_next = p3_sync[d];
                end else if (p3_sync[d] == stable_reg) begin
                    cnt_next = 5'h0;
                end else if (cnt_reg >= DEBOUNCE_CYCLES - 5'h1) begin
                    cnt_next = 5'h0;
                    stable_next = p3_sync[d];
                end else begin
                    cnt_next = cnt_reg + 5'h1;
                end
            end
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    cnt_reg <= 5'h0;
                    stable_reg <= 1'b0;
                end else begin
                    cnt_reg <= cnt_next;
                    stable_reg <= stable_next;
                end
            end
            assign p3_clean[d] = stable_reg;
        end
    endgenerate

    // --------------------
    // event detection
    // --------------------
    // port4: any edge; port3 detect pins: edge or high level
    always_comb begin
        event_set = '0;
        event_set.port4 = p4_sync ^ p4_prev_reg;
        for (int k = 0; k < 3; k++) begin
            if (detect_type_reg[TRIGGER_LEVEL_LSB + k]) begin
                event_set.port3[DETECT_PIN_POS[k]] = p3_clean[k];
            end else begin
                event_set.port3[DETECT_PIN_POS[k]] = p3_clean[k] ^ p3_prev_reg[k];
            end
        end
    end

    // previous levels for edge detection
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            p4_prev_reg <= 8'h00;
            p3_prev_reg <= 3'h0;
        end else begin
            p4_prev_reg <= p4_sync;
            p3_prev_reg <= p3_clean;
        end
    end

    // --------------------
    // apb decode
    // --------------------
    always_comb begin
        reg_index = paddr[9:2];
        addr_ok = (paddr[1:0] == 2'h0) && (paddr[APB_ADDR_W-1:10] == 2'h0);
        setup_phase = psel && !penable;
        access_done = psel && penable && pready_reg;
        // input pins show the pin through the inversion, outputs the stored bit
        data_view = (cfg_reg.pin_data & ~cfg_reg.direction) |
                    ((p4_sync ^ cfg_reg.invert) & cfg_reg.direction);
        read_hit = 1'b1;
        read_byte = 8'h00;
        if (!addr_ok) begin
            read_hit = 1'b0;
        end else begin
            unique case (reg_index)
                IDX_PORT4_DIRECTION: read_byte = cfg_reg.direction;
                IDX_PORT4_PIN_DATA: read_byte = data_view;
                IDX_PORT4_POLARITY_INVERT: read_byte = cfg_reg.invert;
                IDX_PORT4_FUNCTION_SELECT: read_byte = cfg_reg.function_sel;
                IDX_PORT3_DETECT_TYPE: read_byte = detect_type_reg;
                IDX_SUSPEND_LED_MODE: read_byte = {led_mode_reg, 6'h00};
                IDX_PORT3_EVENT_STATUS: read_byte = status_reg.port3;
                IDX_PORT4_EVENT_STATUS: read_byte = status_reg.port4;
                IDX_PORT3_EVENT_MASK: read_byte = mask_reg.port3;
                IDX_PORT4_EVENT_MASK: read_byte = mask_reg.port4;
                default: read_hit = 1'b0;
            endcase
        end
    end

    // answer one cycle after setup; read data captured at setup
    always_comb begin
        pready_next = setup_phase;
        pslverr_next = setup_phase && !read_hit;
        prdata_next = prdata_reg;
        if (setup_phase) begin
            prdata_next = (!pwrite && read_hit) ? {24'h000000, read_byte} : 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // --------------------
    // configuration registers
    // --------------------
    always_comb begin
        cfg_next = cfg_reg;
        detect_type_next = detect_type_reg;
        led_mode_next = led_mode_reg;
        mask_next = mask_reg;
        if (access_done && pwrite && !pslverr_reg) begin
            unique case (reg_index)
                IDX_PORT4_DIRECTION: cfg_next.direction = pwdata[7:0];
                IDX_PORT4_PIN_DATA: begin
                    // only output bits take the write
                    cfg_next.pin_data = (cfg_reg.pin_data & cfg_reg.direction) |
                                        (pwdata[7:0] & ~cfg_reg.direction);
                end
                IDX_PORT4_POLARITY_INVERT: cfg_next.invert = pwdata[7:0];
                IDX_PORT4_FUNCTION_SELECT: cfg_next.function_sel = pwdata[7:0];
                IDX_PORT3_DETECT_TYPE: detect_type_next = pwdata[7:0] & 8'h77;
                IDX_SUSPEND_LED_MODE: led_mode_next = led_mode_t'(pwdata[LED_MODE_LSB +: 2]);
                IDX_PORT3_EVENT_MASK: mask_next.port3 = pwdata[7:0];
                IDX_PORT4_EVENT_MASK: mask_next.port4 = pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cfg_reg.direction <= RST_DIRECTION;
            cfg_reg.pin_data <= RST_PIN_DATA;
            cfg_reg.invert <= RST_INVERT;
            cfg_reg.function_sel <= RST_FUNCTION;
            detect_type_reg <= RST_DETECT_TYPE;
            led_mode_reg <= led_mode_t'(RST_LED_MODE);
            mask_reg <= {RST_MASK, RST_MASK};
        end else begin
            cfg_reg <= cfg_next;
            detect_type_reg <= detect_type_next;
            led_mode_reg <= led_mode_next;
            mask_reg <= mask_next;
        end
    end

    // --------------------
    // event status and interrupt
    // --------------------
    // a read clears only bits it returned; a new event wins over the clear
    always_comb begin
        read_clear = '0;
        if (access_done && !pwrite && !pslverr_reg) begin
            if (reg_index == IDX_PORT3_EVENT_STATUS) begin
                read_clear.port3 = prdata_reg[7:0];
            end
            if (reg_index == IDX_PORT4_EVENT_STATUS) begin
                read_clear.port4 = prdata_reg[7:0];
            end
        end
        status_next = (status_reg & ~read_clear) | event_set;
        irq_next = |(status_reg & mask_reg);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg <= irq_next;
        end
    end

    // --------------------
    // pin drive and function mux
    // --------------------
    genvar p;
    generate
        for (p = 0; p < 8; p++) begin : g_pin
            always_comb begin
                if (cfg_reg.function_sel[p]) begin
                    if (p % 2 == 1) begin
                        pin_out_next[p] = led_level;
                        pin_oe_next[p] = led_drive;
                    end else begin
                        pin_out_next[p] = watchdog_timeout_out_n;
                        pin_oe_next[p] = 1'b1;
                    end
                end else begin
                    pin_out_next[p] = cfg_reg.pin_data[p] ^ cfg_reg.invert[p];
                    pin_oe_next[p] = ~cfg_reg.direction[p];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_out_reg <= 8'h00;
            pin_oe_reg <= 8'h00;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // --------------------
    // outputs
    // --------------------
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign io_port_four_out = pin_out_reg;
    assign io_port_four_oe = pin_oe_reg;
    assign irq = irq_reg;
endmodule

// ==== tb/pin_board.sv ====
// board model: resolves the port4 pin levels seen by the device
`timescale 1ns/10ps
module pin_board (
    input wire logic [7:0] drive_oe,
    input wire logic [7:0] drive_val,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_level
);
    // a driven pin shows the device level, an undriven one the board level
    assign pin_level = (drive_oe & drive_val) | (~drive_oe & ext_level);
endmodule

// ==== tb/io_port_asserts.sv ====
// checker: bus answer timing and pin reset state of the i/o port block
`timescale 1ns/10ps
module io_port_asserts
    import io_port_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] io_port_four_out,
    input wire logic [7:0] io_port_four_oe,
    input wire logic irq
);
    // all checks run on the one block clock
    default clocking @(posedge clk); endclocking
    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    a_ready_after_setup: assert property (disable iff (sys_rst)
        psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (disable iff (sys_rst)
        pready |=> !pready) else $error("ready held too long");
    a_error_reads_zero: assert property (disable iff (sys_rst)
        pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not zero");
    a_misaligned_refused: assert property (disable iff (sys_rst)
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr) else $error("misaligned accepted");
    a_upper_bits_zero: assert property (disable iff (sys_rst)
        pready |-> prdata[31:8] == 24'h0) else $error("read data upper bits set");
    a_error_with_ready: assert property (disable iff (sys_rst)
        pslverr |-> pready) else $error("error without ready");
    // ----------------------------------------
    // pin state around reset
    // ----------------------------------------
    a_reset_pins_input: assert property (
        sys_rst |=> io_port_four_oe == 8'h00 && !irq) else $error("pins driven after reset");
    a_reset_out_low: assert property (
        sys_rst ##1 !sys_rst |-> io_port_four_out == 8'h00) else $error("out not low after reset");
    // main scenarios reached
    c_refused: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
    c_write: cover property (pready && pwrite);
endmodule

bind io_port_four_with_pin_mux io_port_asserts chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_port_four_out(io_port_four_out),
    .io_port_four_oe(io_port_four_oe), .irq(irq));

// ==== tb/io_port_four_with_pin_mux_tb.sv ====
// testbench: register, pin, event and detect scenarios for the i/o port block
`timescale 1ns/10ps
module io_port_four_with_pin_mux_tb;
    import io_port_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pin_in;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] ext = 8'h00;
    logic [2:0] det = 3'h0;
    logic wdt_n = 1'b1;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    int mismatches = 0;
    int compares = 0;

    // ----------------------------------------
    // clock, board and device
    // ----------------------------------------
    always #5 clk = ~clk;

    pin_board board (.drive_oe(pin_oe), .drive_val(pin_out), .ext_level(ext), .pin_level(pin_in));

    io_port_four_with_pin_mux #(.LED_FAST_HALF(28'h4), .LED_SLOW_HALF(28'h10)) DUT (
        .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_port_four_in(pin_in), .io_port_four_out(pin_out), .io_port_four_oe(pin_oe),
        .io_port_three_detect_in(det), .watchdog_timeout_out_n(wdt_n), .irq(irq));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer; request held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        check("access cycles", 32'h1, n);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input string name);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        check(name, {24'h0, exp}, rdat);
    endtask

    task automatic blink(input logic [7:0] mode, input int lo, input int hi);
        int n;
        logic prev;
        n = 0;
        wr(IDX_SUSPEND_LED_MODE, mode);
        cyc(4);
        repeat (40) begin
            prev = pin_in[1];
            @(posedge clk);
            if (pin_in[1] !== prev) n++;
        end
        check("blink toggles", 32'h1, {31'h0, (n >= lo && n <= hi)});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rd(IDX_PORT4_DIRECTION, 8'hFF, "direction");
        rd(IDX_PORT4_PIN_DATA, 8'h00, "pin data");
        rd(IDX_PORT4_POLARITY_INVERT, 8'h00, "invert");
        rd(IDX_PORT4_FUNCTION_SELECT, 8'h00, "function");
        rd(IDX_PORT3_DETECT_TYPE, 8'h00, "detect type");
        check("oe", 32'h0, {24'h0, pin_oe});
        $display("test reset values done");
    endtask

    task automatic t_direction;
        @(posedge clk);
        ext <= 8'h30;
        wr(IDX_PORT4_DIRECTION, 8'hF0);
        wr(IDX_PORT4_PIN_DATA, 8'hA5);
        cyc(8);
        check("oe", 32'h0F, {24'h0, pin_oe});
        check("out low", 32'h5, {28'h0, pin_out[3:0]});
        rd(IDX_PORT4_PIN_DATA, 8'h35, "mixed data");
        wr(IDX_PORT4_DIRECTION, 8'h00);
        cyc(2);
        check("out", 32'h05, {24'h0, pin_out});
        $display("test direction done");
    endtask

    task automatic t_invert;
        wr(IDX_PORT4_POLARITY_INVERT, 8'hFF);
        cyc(2);
        check("inverted out", 32'hFA, {24'h0, pin_out});
        wr(IDX_PORT4_DIRECTION, 8'hF0);
        @(posedge clk);
        ext <= 8'h50;
        cyc(8);
        rd(IDX_PORT4_PIN_DATA, 8'hA5, "inverted data");
        wr(IDX_PORT4_POLARITY_INVERT, 8'h00);
        wr(IDX_PORT4_DIRECTION, 8'hFF);
        $display("test invert done");
    endtask

    task automatic t_events;
        cyc(8);
        apb(1'b0, {2'b00, IDX_PORT4_EVENT_STATUS, 2'b00}, 8'h00);
        wr(IDX_PORT4_EVENT_MASK, 8'h01);
        @(posedge clk);
        ext <= 8'h51;
        cyc(8);
        check("irq set", 32'h1, {31'h0, irq});
        rd(IDX_PORT4_EVENT_STATUS, 8'h01, "status");
        cyc(2);
        check("irq clear", 32'h0, {31'h0, irq});
        rd(IDX_PORT4_EVENT_STATUS, 8'h00, "status cleared");
        @(posedge clk);
        ext <= 8'h53;
        cyc(8);
        check("irq masked", 32'h0, {31'h0, irq});
        rd(IDX_PORT4_EVENT_STATUS, 8'h02, "masked status");
        $display("test events done");
    endtask

    task automatic t_function;
        wr(IDX_SUSPEND_LED_MODE, 8'h40);
        wr(IDX_PORT4_FUNCTION_SELECT, 8'h03);
        @(posedge clk);
        wdt_n <= 1'b0;
        cyc(3);
        check("muxed out", 32'h0, {30'h0, pin_out[1:0]});
        check("muxed oe", 32'h3, {30'h0, pin_oe[1:0]});
        @(posedge clk);
        wdt_n <= 1'b1;
        cyc(3);
        check("watchdog pin", 32'h1, {31'h0, pin_out[0]});
        wr(IDX_SUSPEND_LED_MODE, 8'h00);
        cyc(2);
        check("led tristate", 32'h0, {31'h0, pin_oe[1]});
        blink(8'h80, 9, 11);
        blink(8'hC0, 2, 3);
        wr(IDX_PORT4_FUNCTION_SELECT, 8'h00);
        $display("test function select done");
    endtask

    task automatic t_detect;
        apb(1'b0, {2'b00, IDX_PORT3_EVENT_STATUS, 2'b00}, 8'h00);
        @(posedge clk);
        det <= 3'b001;
        cyc(8);
        rd(IDX_PORT3_EVENT_STATUS, 8'h01, "edge detect");
        wr(IDX_PORT3_DETECT_TYPE, 8'h02);
        @(posedge clk);
        det <= 3'b011;
        cyc(8);
        rd(IDX_PORT3_EVENT_STATUS, 8'h02, "level detect");
        rd(IDX_PORT3_EVENT_STATUS, 8'h02, "level again");
        @(posedge clk);
        det <= 3'b001;
        cyc(8);
        wr(IDX_PORT3_DETECT_TYPE, 8'h40);
        apb(1'b0, {2'b00, IDX_PORT3_EVENT_STATUS, 2'b00}, 8'h00);
        @(posedge clk);
        det <= 3'b101;
        cyc(6);
        det <= 3'b001;
        cyc(30);
        rd(IDX_PORT3_EVENT_STATUS, 8'h00, "short pulse");
        @(posedge clk);
        det <= 3'b101;
        cyc(30);
        rd(IDX_PORT3_EVENT_STATUS, 8'h20, "long pulse");
        $display("test detect done");
    endtask

    task automatic t_refuse;
        apb(1'b0, 12'h040, 8'h00);
        check("unmapped err", 32'h1, {31'h0, rerr});
        check("unmapped data", 32'h0, rdat);
        apb(1'b1, 12'h3D1, 8'h00);
        check("misaligned err", 32'h1, {31'h0, rerr});
        rd(IDX_PORT4_DIRECTION, 8'hFF, "direction kept");
        $display("test refused access done");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_direction();
        t_invert();
        t_events();
        t_function();
        t_detect();
        t_refuse();
        end_sim();
    end

    initial begin
        #200000;
        mismatches++;
        end_sim();
    end
endmodule
